// file: rio_pin_ctrl.v
// Operation
// - latest 16-bit result held read-only, zero after reset
// - io config resets to zero: pins inputs, routing code 00
// - sync falling edge clears fifo only while flush enable is set
// - interrupt event is data-ready with fifo off, else fifo interrupt
// - code 00: interrupt pin, or data-out/ready on lead-frame package
// - code 01: event on clock pin, overriding clock output selection
// - code 10: event on gp pins 0 and 2, overriding their output control
// - code 11: data-ready on data-out pin, no fifo interrupt routed
// - value bits 7..4 drive gp pins 4..1 when set as outputs
// - direction bits 3..0 pick output (1) or input (0) for pins 4..1
// - standby indicator owns gp pin 4 above all other settings
// - interrupt routing owns gp pin 2 above its direction and value
`timescale 1ns/1ps
`default_nettype none
`include "rio_regs.vh"

module rio_pin_ctrl (
	input  wire        core_clk,             // main clock, 100 MHz
	input  wire        rst_n,                // async reset, active low
	input  wire        sclk,                 // serial clock pin
	input  wire        cs_n,                 // serial chip select pin, active low
	input  wire        mosi,                 // serial data in pin
	output wire        miso,                 // serial data out pin
	output wire        miso_oe,              // high while miso driven
	input  wire        sync_n,               // sync pin, active low
	input  wire        pkg_lead_frame,       // package strap, 1 = lead-frame
	input  wire        conv_done,            // pulse: conversion finished
	input  wire [15:0] conv_result,          // result, valid with conv_done
	input  wire        data_ready,           // data-ready level
	input  wire        fifo_en,              // fifo enabled level
	input  wire        fifo_irq,             // fifo interrupt level
	input  wire        standby_indicator_en, // standby indicator enable
	input  wire        standby_state,        // device in standby
	input  wire        clk_out_en,           // clock output selected
	input  wire        clk_src,              // clock to show on clock pin
	output reg         fifo_clear,           // pulse: clear fifo contents
	output reg         int_pin,              // dedicated interrupt pin
	output reg         dout_rdy_sel,         // data-out pin carries ready
	output reg         dout_rdy,             // ready level for data-out pin
	output reg         clk_pin_out,          // clock pin level
	output reg         clk_pin_oe,           // clock pin drive enable
	output wire        gp_pin0_out,          // gp pin 0 level
	output wire        gp_pin0_oe,           // gp pin 0 drive enable
	output wire        gp_pin1_out,          // gp pin 1 level
	output wire        gp_pin1_oe,           // gp pin 1 drive enable
	output wire        gp_pin2_out,          // gp pin 2 level
	output wire        gp_pin2_oe,           // gp pin 2 drive enable
	output wire        gp_pin3_out,          // gp pin 3 level
	output wire        gp_pin3_oe,           // gp pin 3 drive enable
	output wire        gp_pin4_out,          // gp pin 4 level
	output wire        gp_pin4_oe,           // gp pin 4 drive enable
	output wire [15:0] conversion_result_word, // result register contents
	output wire [15:0] pin_io_config         // io config register contents
);

	reg  [15:0]                result_q;
	reg  [`RIO_IOCFG_BITS-1:0] iocfg_q;
	reg  [1:0]                 sync_s;
	reg                        sync_prev_q;
	reg  [1:0]                 strap_s;
	reg                        strap_done_q;
	reg  [1:0]                 strap_fill_q;
	reg                        lead_frame_q;
	reg  [`RIO_GP_PINS-1:0]    gp_out_q;
	reg  [`RIO_GP_PINS-1:0]    gp_oe_q;
	reg  [15:0]                rd_word;
	wire [`RIO_ADDR_W-1:0]     reg_addr;
	wire                       wr_stb;
	wire [15:0]                wr_data;
	wire [1:0]                 route;
	wire                       irq_evt;
	wire                       sync_fall;
	wire [`RIO_GP_PINS-1:0]    gp_base_out;
	wire [`RIO_GP_PINS-1:0]    gp_base_oe;

	// true when the routing field holds the given code
	function route_is;
		input [1:0] sel;
		input [1:0] code;
		begin
			route_is = (sel == code);
		end
	endfunction

	rio_spi_slave rio_spi_slave_inst (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.sclk     (sclk),
		.cs_n     (cs_n),
		.mosi     (mosi),
		.miso     (miso),
		.miso_oe  (miso_oe),
		.reg_addr (reg_addr),
		.wr_stb   (wr_stb),
		.wr_data  (wr_data),
		.rd_stb   (),
		.rd_data  (rd_word)
	);

	assign route                  = iocfg_q[`RIO_INT_SEL_HI:`RIO_INT_SEL_LO];
	assign conversion_result_word = result_q;
	assign pin_io_config          = {`RIO_IOCFG_PAD, iocfg_q};

	// register read mux, reserved bits and unmapped addresses read zero
	always @* begin
		case (reg_addr)
			`RIO_ADDR_RESULT: rd_word = result_q;
			`RIO_ADDR_IOCFG:  rd_word = {`RIO_IOCFG_PAD, iocfg_q};
			default:          rd_word = `RIO_WORD_ZERO;
		endcase
	end

	// result register, loaded whole at the end of each conversion
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			result_q <= `RIO_RESULT_RST;
		else if (conv_done)
			result_q <= conv_result;
	end

	// io config register, only the defined low bits are writable
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			iocfg_q <= `RIO_IOCFG_RST;
		else if (wr_stb && reg_addr == `RIO_ADDR_IOCFG)
			iocfg_q <= wr_data[`RIO_IOCFG_BITS-1:0];
	end

	// sync pin synchroniser and falling-edge detector
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_s      <= 2'h3;
			sync_prev_q <= 1'b1;
		end else begin
			sync_s      <= {sync_s[0], sync_n};
			sync_prev_q <= sync_s[1];
		end
	end

	assign sync_fall = sync_prev_q & ~sync_s[1];

	// fifo clear pulse, gated by the flush enable bit
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			fifo_clear <= 1'b0;
		else
			fifo_clear <= sync_fall & iocfg_q[`RIO_BIT_SYNC_CLR];
	end

	// package strap, synchronised then caught once after reset release
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_s      <= 2'h0;
			strap_fill_q <= 2'h0;
			strap_done_q <= 1'b0;
			lead_frame_q <= 1'b0;
		end else begin
			strap_s      <= {strap_s[0], pkg_lead_frame};
			strap_fill_q <= {strap_fill_q[0], 1'b1};
			// wait until the synchroniser holds a real pin sample, not its reset value
			if (strap_fill_q[1] && !strap_done_q) begin
				strap_done_q <= 1'b1;
				lead_frame_q <= strap_s[1];
			end
		end
	end

	// interrupt event source
	assign irq_evt = fifo_en ? fifo_irq : data_ready;

	// interrupt and data-out ready routing
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_pin      <= 1'b0;
			dout_rdy_sel <= 1'b0;
			dout_rdy     <= 1'b0;
		end else begin
			int_pin      <= 1'b0;
			dout_rdy_sel <= 1'b0;
			dout_rdy     <= 1'b0;
			if (route_is(route, `RIO_ROUTE_INT)) begin
				if (lead_frame_q) begin
					dout_rdy_sel <= 1'b1;
					dout_rdy     <= data_ready;
				end else begin
					int_pin <= irq_evt;
				end
			end else if (route_is(route, `RIO_ROUTE_DOUT)) begin
				dout_rdy_sel <= 1'b1;
				dout_rdy     <= data_ready;
			end
		end
	end

	// clock pin: interrupt routing overrides the clock output selection
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_pin_out <= 1'b0;
			clk_pin_oe  <= 1'b0;
		end else if (route_is(route, `RIO_ROUTE_CLK)) begin
			clk_pin_out <= irq_evt;
			clk_pin_oe  <= 1'b1;
		end else begin
			clk_pin_out <= clk_src & clk_out_en;
			clk_pin_oe  <= clk_out_en;
		end
	end

	// plain value and direction for pins 1..4, pin 0 has none
	assign gp_base_out[`RIO_GP_ROUTE_PIN] = 1'b0;
	assign gp_base_oe[`RIO_GP_ROUTE_PIN]  = 1'b0;
	genvar gi;
	generate
		for (gi = 1; gi < `RIO_GP_PINS; gi = gi + 1) begin : g_gp
			assign gp_base_oe[gi]  = iocfg_q[`RIO_GP_DIR_LO + gi - 1];
			assign gp_base_out[gi] = iocfg_q[`RIO_GP_VAL_LO + gi - 1] &
			                         iocfg_q[`RIO_GP_DIR_LO + gi - 1];
		end
	endgenerate

	// gp pin outputs with overrides applied, registered
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gp_out_q <= {`RIO_GP_PINS{1'b0}};
			gp_oe_q  <= {`RIO_GP_PINS{1'b0}};
		end else begin
			gp_out_q <= gp_base_out;
			gp_oe_q  <= gp_base_oe;
			if (route_is(route, `RIO_ROUTE_GP0)) begin
				gp_out_q[`RIO_GP_ROUTE_PIN] <= irq_evt;
				gp_oe_q[`RIO_GP_ROUTE_PIN]  <= 1'b1;
				gp_out_q[`RIO_GP_INT_PIN]   <= irq_evt;
				gp_oe_q[`RIO_GP_INT_PIN]    <= 1'b1;
			end
			if (standby_indicator_en) begin
				gp_out_q[`RIO_GP_STBY_PIN] <= standby_state;
				gp_oe_q[`RIO_GP_STBY_PIN]  <= 1'b1;
			end
		end
	end

	assign gp_pin0_out = gp_out_q[0];
	assign gp_pin0_oe  = gp_oe_q[0];
	assign gp_pin1_out = gp_out_q[1];
	assign gp_pin1_oe  = gp_oe_q[1];
	assign gp_pin2_out = gp_out_q[2];
	assign gp_pin2_oe  = gp_oe_q[2];
	assign gp_pin3_out = gp_out_q[3];
	assign gp_pin3_oe  = gp_oe_q[3];
	assign gp_pin4_out = gp_out_q[4];
	assign gp_pin4_oe  = gp_oe_q[4];

endmodule
`default_nettype wire

// file: rio_regs.vh
`ifndef RIO_REGS_VH
`define RIO_REGS_VH

// register addresses as seen in the serial command byte
`define RIO_ADDR_W          7
`define RIO_ADDR_RESULT     7'h02
`define RIO_ADDR_IOCFG      7'h03

// reset values
`define RIO_RESULT_RST      16'h0000
`define RIO_IOCFG_RST       11'h000
`define RIO_WORD_ZERO       16'h0000

// io config field layout, bits 15..11 are reserved and read zero
`define RIO_IOCFG_BITS      11
`define RIO_IOCFG_PAD       5'h00
`define RIO_BIT_SYNC_CLR    10
`define RIO_INT_SEL_HI      9
`define RIO_INT_SEL_LO      8
`define RIO_GP_VAL_LO       4
`define RIO_GP_DIR_LO       0
`define RIO_GP_PINS         5
`define RIO_GP_ROUTE_PIN    0
`define RIO_GP_INT_PIN      2
`define RIO_GP_STBY_PIN     4

// interrupt routing codes
`define RIO_ROUTE_INT       2'h0
`define RIO_ROUTE_CLK       2'h1
`define RIO_ROUTE_GP0       2'h2
`define RIO_ROUTE_DOUT      2'h3

// serial frame: 8 command bits then 16 data bits, msb first
`define RIO_SPI_CNT_W       5
`define RIO_SPI_CNT_ZERO    5'h00
`define RIO_SPI_CNT_ONE     5'h01
`define RIO_SPI_CMD_LAST    5'h07
`define RIO_SPI_CMD_BITS    5'h08
`define RIO_SPI_FRAME_LAST  5'h17
`define RIO_SPI_RD_BIT      7

`endif

// file: rio_spi_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "rio_regs.vh"

module rio_spi_slave (
	input  wire                   core_clk,  // main clock
	input  wire                   rst_n,     // async reset, active low
	input  wire                   sclk,      // serial clock pin
	input  wire                   cs_n,      // chip select pin, active low
	input  wire                   mosi,      // serial data in pin
	output wire                   miso,      // serial data out pin
	output wire                   miso_oe,   // high while miso is driven
	output reg  [`RIO_ADDR_W-1:0] reg_addr,  // address of current frame
	output reg                    wr_stb,    // one-cycle write strobe
	output reg  [15:0]            wr_data,   // write data, valid with wr_stb
	output reg                    rd_stb,    // one-cycle pulse when read word is taken
	input  wire [15:0]            rd_data    // read word for reg_addr
);

	reg [2:0]                sclk_s;
	reg [1:0]                cs_s;
	reg [1:0]                mosi_s;
	reg [`RIO_SPI_CNT_W-1:0] cnt_q;
	reg [15:0]               sh_in_q;
	reg [15:0]               sh_out_q;
	reg                      rd_q;
	reg                      load_q;

	wire sclk_rise = sclk_s[1] & ~sclk_s[2];
	wire sclk_fall = ~sclk_s[1] & sclk_s[2];
	wire sel       = ~cs_s[1];

	assign miso    = sh_out_q[15];
	assign miso_oe = sel & rd_q & (cnt_q >= `RIO_SPI_CMD_BITS);

	// pin synchronisers, stage 0 feeds only stage 1
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_s <= 3'h0;
			cs_s   <= 2'h3;
			mosi_s <= 2'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk};
			cs_s   <= {cs_s[0], cs_n};
			mosi_s <= {mosi_s[0], mosi};
		end
	end

	// frame shifter: sample on rising sclk, present on falling sclk
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q    <= `RIO_SPI_CNT_ZERO;
			sh_in_q  <= `RIO_WORD_ZERO;
			sh_out_q <= `RIO_WORD_ZERO;
			rd_q     <= 1'b0;
			load_q   <= 1'b0;
			reg_addr <= {`RIO_ADDR_W{1'b0}};
			wr_stb   <= 1'b0;
			wr_data  <= `RIO_WORD_ZERO;
			rd_stb   <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			load_q <= 1'b0;
			if (!sel) begin
				cnt_q <= `RIO_SPI_CNT_ZERO;
				rd_q  <= 1'b0;
			end else if (sclk_rise) begin
				sh_in_q <= {sh_in_q[14:0], mosi_s[1]};
				if (cnt_q != `RIO_SPI_FRAME_LAST + `RIO_SPI_CNT_ONE)
					cnt_q <= cnt_q + `RIO_SPI_CNT_ONE;
				if (cnt_q == `RIO_SPI_CMD_LAST) begin
					rd_q     <= sh_in_q[`RIO_SPI_RD_BIT-1];
					reg_addr <= {sh_in_q[`RIO_ADDR_W-2:0], mosi_s[1]};
					load_q   <= sh_in_q[`RIO_SPI_RD_BIT-1];
				end
				if (cnt_q == `RIO_SPI_FRAME_LAST && !rd_q) begin
					wr_stb  <= 1'b1;
					wr_data <= {sh_in_q[14:0], mosi_s[1]};
				end
			end else if (sclk_fall && cnt_q > `RIO_SPI_CMD_BITS) begin
				sh_out_q <= {sh_out_q[14:0], 1'b0};
			end
			// whole word captured in one cycle so a read is never torn
			if (load_q) begin
				sh_out_q <= rd_data;
				rd_stb   <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// file: rio_pin_checker.sv
`timescale 1ns/1ps
`default_nettype none

module rio_pin_checker (
	input wire logic        core_clk,             // clock
	input wire logic        rst_n,                // reset, active low
	input wire logic        sync_n,               // sync pin
	input wire logic        conv_done,            // result strobe
	input wire logic [15:0] conv_result,          // new result
	input wire logic        data_ready,           // ready level
	input wire logic        fifo_en,              // fifo on
	input wire logic        fifo_irq,             // fifo event
	input wire logic        standby_indicator_en, // standby owns pin 4
	input wire logic        standby_state,        // standby level
	input wire logic        fifo_clear,           // clear pulse
	input wire logic        dout_rdy_sel,         // dout carries ready
	input wire logic        dout_rdy,             // ready on dout
	input wire logic        clk_pin_out,          // clock pin level
	input wire logic        clk_pin_oe,           // clock pin drive
	input wire logic        gp_pin0_out,          // gp 0 level
	input wire logic        gp_pin0_oe,           // gp 0 drive
	input wire logic        gp_pin2_out,          // gp 2 level
	input wire logic        gp_pin2_oe,           // gp 2 drive
	input wire logic        gp_pin4_out,          // gp 4 level
	input wire logic        gp_pin4_oe,           // gp 4 drive
	input wire logic [15:0] conversion_result_word, // result register
	input wire logic [15:0] pin_io_config         // config register
);
	// interrupt event as the routing logic should see it
	wire logic ev = fifo_en ? fifo_irq : data_ready;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// result register loads whole words only on completion
	a_result_load: assert property (conv_done
		|=> conversion_result_word == $past(conv_result)) else $error("result not loaded");
	a_result_hold: assert property (!conv_done
		|=> $stable(conversion_result_word)) else $error("result changed");
	a_reserved_zero: assert property (pin_io_config[15:11] == 5'h00)
		else $error("reserved config bits set");
	// routing codes one cycle after the config
	a_clk_route: assert property (pin_io_config[9:8] == 2'h1
		|=> clk_pin_oe && clk_pin_out == $past(ev)) else $error("clock pin route");
	a_gp_route: assert property (pin_io_config[9:8] == 2'h2
		|=> gp_pin0_oe && gp_pin2_oe && gp_pin0_out == $past(ev) && gp_pin2_out == $past(ev))
		else $error("gp pin route");
	a_dout_route: assert property (pin_io_config[9:8] == 2'h3
		|=> dout_rdy_sel && dout_rdy == $past(data_ready)) else $error("dout route");
	a_standby_pin: assert property (standby_indicator_en
		|=> gp_pin4_oe && gp_pin4_out == $past(standby_state)) else $error("standby pin");
	// sync clear pulse and its gate
	a_clear_cause: assert property ($fell(sync_n) && pin_io_config[10]
		|-> ##[1:6] fifo_clear) else $error("missing fifo clear");
	a_clear_gate: assert property (fifo_clear
		|-> $past(pin_io_config[10]) ##1 !fifo_clear) else $error("bad fifo clear");

	c_clear: cover property (fifo_clear);
	c_gp_route: cover property (pin_io_config[9:8] == 2'h2 && ev);
	c_standby: cover property (standby_indicator_en && standby_state);
endmodule

`default_nettype wire

// file: rio_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module rio_host_model (
	input  wire logic core_clk, // clock
	output var logic  sclk,     // serial clock
	output var logic  cs_n,     // select, active low
	output var logic  mosi,     // data to device
	input  wire logic miso      // data from device
);
	// idle bus: clock low, deselected
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// n bits msb first, h core cycles per half period, reply is last 16 bits
	task automatic frame(input logic [23:0] w, input int n, input int h,
		output logic [15:0] rd);
		rd = 16'h0000;
		@(posedge core_clk) cs_n <= 1'b0;
		for (int i = 23; i > 23 - n; i--) begin
			mosi <= w[i];
			repeat (h) @(posedge core_clk);
			rd = {rd[14:0], miso};
			sclk <= 1'b1;
			repeat (h) @(posedge core_clk);
			sclk <= 1'b0;
		end
		repeat (h) @(posedge core_clk);
		cs_n <= 1'b1;
		mosi <= ~mosi;
		repeat (4) @(posedge core_clk);
	endtask
endmodule

`default_nettype wire

// file: test_result_and_io_pin_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_result_and_io_pin_control;
	logic core_clk = 1'b0, rst_n = 1'b0, sync_n = 1'b1, conv_done = 1'b0;
	logic pkg_lead_frame = 1'b0, data_ready = 1'b1, fifo_en = 1'b0, fifo_irq = 1'b0;
	logic standby_indicator_en = 1'b0, standby_state = 1'b0;
	logic clk_out_en = 1'b1, clk_src = 1'b1;
	logic [15:0] conv_result = 16'h0000, r, conversion_result_word, pin_io_config;
	logic sclk, cs_n, mosi, miso, miso_oe, fifo_clear, int_pin, dout_rdy_sel, dout_rdy;
	logic clk_pin_out, clk_pin_oe, gp_pin0_out, gp_pin0_oe, gp_pin1_out, gp_pin1_oe;
	logic gp_pin2_out, gp_pin2_oe, gp_pin3_out, gp_pin3_oe, gp_pin4_out, gp_pin4_oe;
	logic ev;
	int err_count = 0, tests_run = 0, c, f;
	// gp pins 4..1 as {drive enables, levels}
	wire logic [15:0] gp_vec = {8'h00, gp_pin4_oe, gp_pin3_oe, gp_pin2_oe, gp_pin1_oe,
		gp_pin4_out, gp_pin3_out, gp_pin2_out, gp_pin1_out};

	rio_pin_ctrl rio_pin_ctrl_inst (.*);
	rio_host_model rio_host_model_inst (.*);

	// 100 MHz clock
	always #5 core_clk = ~core_clk;

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] x;
		rio_host_model_inst.frame({1'b0, a, d}, 24, 5, x);
	endtask

	task automatic rd(input logic [6:0] a, input int h, input logic [15:0] e);
		logic [15:0] x;
		rio_host_model_inst.frame({1'b1, a, 16'h0000}, 24, h, x);
		chk("read", x, e);
	endtask

	// sync held low 12 cycles; count clear pulses meanwhile
	task automatic sync_pulse(input logic [15:0] e);
		logic [15:0] n;
		n = 16'h0000;
		@(posedge core_clk) sync_n <= 1'b0;
		repeat (12) @(posedge core_clk) n = n + {15'h0000, fifo_clear};
		sync_n <= 1'b1;
		chk("clears", n, e);
	endtask

	// watchdog: the run needs well under 10000 cycles
	initial begin
		#200000;
		err_count++;
		stop_test();
	end

	// main sequence
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(7'h02, 5, 16'h0000);
		rd(7'h03, 9, 16'h0000);
		chk("gp", gp_vec, 16'h0000);
		conv_result <= 16'hA5C3;
		conv_done <= 1'b1;
		@(posedge core_clk) conv_done <= 1'b0;
		wr(7'h02, 16'h1234);
		chk("result", conversion_result_word, 16'hA5C3);
		chk("miso_oe", {15'h0000, miso_oe}, 16'h0000);
		rd(7'h02, 9, 16'hA5C3);
		rd(7'h7F, 5, 16'h0000);
		// reserved bits and a cut-short frame
		wr(7'h03, 16'hFFFF);
		chk("cfg", pin_io_config, 16'h07FF);
		rd(7'h03, 5, 16'h07FF);
		rio_host_model_inst.frame(24'h030000, 12, 5, r);
		rd(7'h03, 5, 16'h07FF);
		wr(7'h03, 16'h0036);
		chk("gp", gp_vec, 16'h0062);
		standby_indicator_en <= 1'b1;
		standby_state <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("gp", gp_vec, 16'h00EA);
		standby_state <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("gp", gp_vec, 16'h00E2);
		standby_indicator_en <= 1'b0;
		// every routing code; event from data-ready, idle fifo, firing fifo
		for (c = 0; c < 4; c++) begin
			wr(7'h03, {6'h00, c[1:0], 8'h02});
			for (f = 0; f < 3; f++) begin
				fifo_en  <= f != 0;
				fifo_irq <= f == 2;
				ev = f != 1;
				repeat (3) @(posedge core_clk);
				chk("int", {15'h0000, int_pin}, {15'h0000, c == 0 && ev});
				chk("clk", {14'h0000, clk_pin_oe, clk_pin_out}, {14'h0000, 1'b1, c != 1 || ev});
				chk("gp02", {12'h000, gp_pin0_oe, gp_pin0_out & gp_pin0_oe, gp_pin2_oe, gp_pin2_out},
					{12'h000, c == 2, c == 2 && ev, 1'b1, c == 2 && ev});
				chk("dout", {14'h0000, dout_rdy_sel, dout_rdy}, {14'h0000, c == 3, c == 3});
			end
		end
		sync_pulse(16'h0000);
		wr(7'h03, 16'h0400);
		sync_pulse(16'h0001);
		// reset again in mid-run with the lead-frame strap, routing back to code 00
		rst_n <= 1'b0;
		pkg_lead_frame <= 1'b1;
		fifo_en <= 1'b0;
		data_ready <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		// strap is caught at the third edge, routing follows one edge later
		repeat (6) @(posedge core_clk);
		chk("cfg", pin_io_config, 16'h0000);
		chk("gp", gp_vec, 16'h0000);
		chk("dout", {14'h0000, dout_rdy_sel, dout_rdy}, 16'h0002);
		data_ready <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("dout", {14'h0000, dout_rdy_sel, dout_rdy}, 16'h0003);
		chk("int", {15'h0000, int_pin}, 16'h0000);
		rd(7'h02, 4, 16'h0000);
		stop_test();
	end
endmodule

bind rio_pin_ctrl rio_pin_checker rio_pin_checker_inst (.*);

`default_nettype wire
